// *** core/timer_cmd_pkg.sv ***
// constants and types for the timer command byte decoder
package timer_cmd_pkg;

    localparam int         NUM_COUNTERS  = 3;
    localparam logic [7:0] CMD_ADDR      = 8'h43;
    localparam logic [7:0] COUNT_BASE    = 8'h40;

    // command byte field positions
    localparam int TGT_HI   = 7;
    localparam int TGT_LO   = 6;
    localparam int ACC_HI   = 5;
    localparam int ACC_LO   = 4;
    localparam int MODE_HI  = 3;
    localparam int MODE_LO  = 1;
    localparam int BCD_BIT  = 0;
    localparam int RB_NOCNT = 5;
    localparam int RB_NOSTS = 4;
    localparam int RB_SEL0  = 1;

    localparam logic [1:0] TGT_READBACK = 2'h3;

    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LSB   = 2'h1;
    localparam logic [1:0] ACC_MSB   = 2'h2;
    localparam logic [1:0] ACC_BOTH  = 2'h3;

    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

    typedef enum logic [2:0] {
        MODE_TERMINAL,
        MODE_ONESHOT,
        MODE_RATE,
        MODE_SQUARE,
        MODE_SOFT_STROBE,
        MODE_HW_STROBE
    } mode_t;

    localparam logic [1:0] RST_ACCESS = ACC_LSB;
    localparam mode_t      RST_MODE   = MODE_TERMINAL;
    localparam logic       RST_BCD    = 1'b0;

    // bit 3 is a don't-care for patterns x10 and x11
    function automatic mode_t decode_mode(input logic [2:0] bits);
        mode_t m;
        m = MODE_TERMINAL;
        unique case (bits[1:0])
            2'h2: m = MODE_RATE;
            2'h3: m = MODE_SQUARE;
            2'h0: m = bits[2] ? MODE_SOFT_STROBE : MODE_TERMINAL;
            2'h1: m = bits[2] ? MODE_HW_STROBE : MODE_ONESHOT;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] mode_number(input mode_t m);
        logic [2:0] n;
        n = 3'h0;
        unique case (m)
            MODE_TERMINAL:    n = 3'h0;
            MODE_ONESHOT:     n = 3'h1;
            MODE_RATE:        n = 3'h2;
            MODE_SQUARE:      n = 3'h3;
            MODE_SOFT_STROBE: n = 3'h4;
            MODE_HW_STROBE:   n = 3'h5;
        endcase
        return n;
    endfunction

endpackage

// *** core/slot_if.sv ***
// carrier between the command decoder and one counter's configuration slot
`timescale 1ns/10ps
`default_nettype none
interface slot_if;
    import timer_cmd_pkg::*;
    logic        cfg_wr;
    logic [7:0]  cfg_byte;
    logic        cnt_wr;
    logic [7:0]  cnt_byte;
    logic [1:0]  access;
    mode_t       mode;
    logic        bcd;
    logic [15:0] load_value;
    logic        load_pulse;
    logic        bad_count;
    logic        msb_next;

    modport decoder (output cfg_wr, cfg_byte, cnt_wr, cnt_byte,
                     input  access, mode, bcd, load_value, load_pulse, bad_count, msb_next);
    modport slot    (input  cfg_wr, cfg_byte, cnt_wr, cnt_byte,
                     output access, mode, bcd, load_value, load_pulse, bad_count, msb_next);
endinterface
`default_nettype wire

// *** core/counter_cfg_slot.sv ***
// per-counter configuration store and count byte sequencer
`timescale 1ns/10ps
`default_nettype none
module counter_cfg_slot (
    input  wire logic clock,
    input  wire logic rst,
    slot_if.slot      bus
);
    import timer_cmd_pkg::*;

    typedef struct packed {
        logic [1:0]  access;
        mode_t       mode;
        logic        bcd;
        logic        msb_next;
        logic [7:0]  low_byte;
        logic [15:0] load_value;
        logic        load_pulse;
        logic        bad_count;
    } slot_state_t;

    slot_state_t state_ff;
    slot_state_t nxt_state;
    logic [15:0] candidate;
    logic        have_word;
    logic        digits_ok;

    always_comb begin
        nxt_state            = state_ff;
        nxt_state.load_pulse = 1'b0;
        nxt_state.bad_count  = 1'b0;
        candidate            = 16'h0000;
        have_word            = 1'b0;
        if (bus.cfg_wr) begin
            nxt_state.access   = bus.cfg_byte[ACC_HI:ACC_LO];
            nxt_state.mode     = decode_mode(bus.cfg_byte[MODE_HI:MODE_LO]);
            nxt_state.bcd      = bus.cfg_byte[BCD_BIT];
            nxt_state.msb_next = 1'b0;
        end else if (bus.cnt_wr) begin
            unique case (state_ff.access)
                ACC_MSB: begin
                    candidate = {bus.cnt_byte, 8'h00};
                    have_word = 1'b1;
                end
                ACC_BOTH: begin
                    if (state_ff.msb_next) begin
                        candidate          = {bus.cnt_byte, state_ff.low_byte};
                        have_word          = 1'b1;
                        nxt_state.msb_next = 1'b0;
                    end else begin
                        nxt_state.low_byte = bus.cnt_byte;
                        nxt_state.msb_next = 1'b1;
                    end
                end
                default: begin
                    candidate = {8'h00, bus.cnt_byte};
                    have_word = 1'b1;
                end
            endcase
        end
        // decimal counts hold four digits each at most nine
        digits_ok = !state_ff.bcd ||
                    ((candidate[15:12] <= BCD_DIGIT_MAX) && (candidate[11:8] <= BCD_DIGIT_MAX) &&
                     (candidate[7:4] <= BCD_DIGIT_MAX) && (candidate[3:0] <= BCD_DIGIT_MAX));
        if (have_word) begin
            if (digits_ok) begin
                nxt_state.load_value = candidate;
                nxt_state.load_pulse = 1'b1;
            end else begin
                nxt_state.bad_count = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= '{access: RST_ACCESS, mode: RST_MODE, bcd: RST_BCD, msb_next: 1'b0,
                          low_byte: 8'h00, load_value: 16'h0000, load_pulse: 1'b0,
                          bad_count: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus.access     = state_ff.access;
    assign bus.mode       = state_ff.mode;
    assign bus.bcd        = state_ff.bcd;
    assign bus.msb_next   = state_ff.msb_next;
    assign bus.load_value = state_ff.load_value;
    assign bus.load_pulse = state_ff.load_pulse;
    assign bus.bad_count  = state_ff.bad_count;

endmodule // counter_cfg_slot
`default_nettype wire

// *** core/timer_cmd_decode.sv ***
// decode of the timer command byte and count byte routing for three counters
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Bits 7:6 pick counter 0, 1 or 2, and 11 means a read-back command instead.
// - Bits 5:4 both zero make the write a count latch for the picked counter.
// - Bits 5:4 give byte order: 01 low only, 10 high only, 11 low then high.
// - Bits 3:1 pick the mode: 000 mode 0, 001 one-shot, 100 soft strobe, 101 hard strobe.
// - Bit 3 is ignored for x10 (rate generator, mode 2) and x11 (square wave, mode 3).
// - Bit 0 picks binary countdown at zero and four-digit decimal countdown at one.
// - In decimal mode a count is taken only if it fits four decimal digits.
// - After a command byte a count may be written any time and is handed on for the mode to use.
// - The command byte is one write-only byte at a single I/O location.
// - In a read-back, bit 5 at zero latches the count of each picked counter, at one it does not.
module timer_cmd_decode (
    input  wire logic                                              clock,
    input  wire logic                                              rst,
    input  wire logic                                              io_wr,
    input  wire logic [7:0]                                        io_addr,
    input  wire logic [7:0]                                        io_data,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0][1:0]       cnt_access,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0][2:0]       cnt_mode,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0]            cnt_bcd,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0]            cnt_msb_next,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0][15:0]      cnt_load_value,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0]            cnt_load,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0]            cnt_bad_count,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0]            cnt_reconfig,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0]            latch_count,
    output logic      [timer_cmd_pkg::NUM_COUNTERS-1:0]            latch_status
);
    import timer_cmd_pkg::*;

    typedef struct packed {
        logic [NUM_COUNTERS-1:0] reconfig;
        logic [NUM_COUNTERS-1:0] latch_cnt;
        logic [NUM_COUNTERS-1:0] latch_sts;
    } dec_state_t;

    dec_state_t              state_ff;
    dec_state_t              nxt_state;
    logic                    cmd_wr;
    logic [1:0]              target;
    logic [1:0]              acc_field;
    logic [NUM_COUNTERS-1:0] cfg_sel;
    logic [NUM_COUNTERS-1:0] cnt_sel;

    assign cmd_wr    = io_wr && (io_addr == CMD_ADDR);
    assign target    = io_data[TGT_HI:TGT_LO];
    assign acc_field = io_data[ACC_HI:ACC_LO];

    always_comb begin
        nxt_state = '0;
        cfg_sel   = '0;
        cnt_sel   = '0;
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            cnt_sel[i] = io_wr && (io_addr == (COUNT_BASE + 8'(i)));
        end
        if (cmd_wr) begin
            if (target == TGT_READBACK) begin
                for (int i = 0; i < NUM_COUNTERS; i++) begin
                    if (io_data[RB_SEL0 + i]) begin
                        nxt_state.latch_cnt[i] = !io_data[RB_NOCNT];
                        nxt_state.latch_sts[i] = !io_data[RB_NOSTS];
                    end
                end
            end else if (acc_field == ACC_LATCH) begin
                nxt_state.latch_cnt[target] = 1'b1;
            end else begin
                cfg_sel[target]            = 1'b1;
                nxt_state.reconfig[target] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cnt_reconfig = state_ff.reconfig;
    assign latch_count  = state_ff.latch_cnt;
    assign latch_status = state_ff.latch_sts;

    genvar g;
    generate
        for (g = 0; g < NUM_COUNTERS; g++) begin : gen_slot
            slot_if link ();
            assign link.cfg_wr   = cfg_sel[g];
            assign link.cfg_byte = io_data;
            assign link.cnt_wr   = cnt_sel[g];
            assign link.cnt_byte = io_data;

            counter_cfg_slot u_slot (
                .clock (clock),
                .rst   (rst),
                .bus   (link.slot)
            );

            assign cnt_access[g]     = link.access;
            assign cnt_mode[g]       = mode_number(link.mode);
            assign cnt_bcd[g]        = link.bcd;
            assign cnt_msb_next[g]   = link.msb_next;
            assign cnt_load_value[g] = link.load_value;
            assign cnt_load[g]       = link.load_pulse;
            assign cnt_bad_count[g]  = link.bad_count;
        end
    endgenerate

endmodule // timer_cmd_decode
`default_nettype wire

// *** verification/timer_cmd_decode_asserts.sv ***
// concurrent checks on the timer command byte decoder ports
`timescale 1ns/10ps
`default_nettype none
module timer_cmd_decode_asserts
    import timer_cmd_pkg::*;
(
    input wire logic             clock,
    input wire logic             rst,
    input wire logic             io_wr,
    input wire logic [7:0]       io_addr,
    input wire logic [7:0]       io_data,
    input wire logic [2:0][1:0]  cnt_access,
    input wire logic [2:0][2:0]  cnt_mode,
    input wire logic [2:0]       cnt_bcd,
    input wire logic [2:0]       cnt_msb_next,
    input wire logic [2:0][15:0] cnt_load_value,
    input wire logic [2:0]       cnt_load,
    input wire logic [2:0]       cnt_bad_count,
    input wire logic [2:0]       cnt_reconfig,
    input wire logic [2:0]       latch_count,
    input wire logic [2:0]       latch_status
);
    import timer_cmd_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    wire logic [1:0] tg  = io_data[7:6];
    wire logic [1:0] ix  = io_addr[1:0];
    wire logic       cmd = io_wr && io_addr == CMD_ADDR;
    wire logic       cfg = cmd && tg != TGT_READBACK && io_data[5:4] != ACC_LATCH;
    wire logic       lat = cmd && tg != TGT_READBACK && io_data[5:4] == ACC_LATCH;
    wire logic       cw  = io_wr && io_addr[7:2] == 6'h10 && ix != 2'h3;
    rb_latch_a: assert property (
        cmd && tg == TGT_READBACK |=> latch_count == (~{3{$past(io_data[5])}} & $past(io_data[3:1])))
        else $error("readback latch mask wrong");
    latch_cmd_a: assert property (
        lat |=> latch_count == 3'(1 << $past(tg)) && cnt_reconfig == 3'h0)
        else $error("count latch command wrong");
    access_set_a: assert property (
        cfg |=> cnt_reconfig == 3'(1 << $past(tg)) && cnt_access[$past(tg)] == $past(io_data[5:4])
            && !cnt_msb_next[$past(tg)]) else $error("access order not taken");
    mode_set_a: assert property (
        cfg |=> cnt_mode[$past(tg)] == ($past(io_data[2]) ? {2'h1, $past(io_data[1])}
            : $past(io_data[3:1]))) else $error("mode decode wrong");
    bcd_set_a: assert property (
        cfg |=> cnt_bcd[$past(tg)] == $past(io_data[0])) else $error("countdown kind wrong");
    bad_refused_a: assert property (
        |cnt_bad_count |-> (cnt_bad_count & cnt_load) == 3'h0 && $stable(cnt_load_value))
        else $error("refused count was loaded");
    lsb_load_a: assert property (
        cw && cnt_access[ix] == ACC_LSB && !cnt_bcd[ix] |=> cnt_load[$past(ix)]
            && cnt_load_value[$past(ix)] == {8'h00, $past(io_data)}) else $error("lsb load wrong");
    quiet_other_a: assert property (
        !(io_wr && io_addr[7:2] == 6'h10) |=> (cnt_load | cnt_bad_count | cnt_reconfig
            | latch_count | latch_status) == 3'h0) else $error("pulse without own write");
    pair_first_a: assert property (
        cw && cnt_access[ix] == ACC_BOTH && !cnt_msb_next[ix] |=> cnt_msb_next[$past(ix)]
            && !cnt_load[$past(ix)]) else $error("first byte of pair wrong");
    cfg_seen_c: cover property (cfg);
    lat_seen_c: cover property (lat);
    load_seen_c: cover property (|cnt_load);
    rb_seen_c: cover property (cmd && tg == TGT_READBACK);
    bad_seen_c: cover property (|cnt_bad_count);
endmodule // timer_cmd_decode_asserts
bind timer_cmd_decode timer_cmd_decode_asserts chk (.clock, .rst, .io_wr, .io_addr, .io_data,
    .cnt_access, .cnt_mode, .cnt_bcd, .cnt_msb_next, .cnt_load_value, .cnt_load,
    .cnt_bad_count, .cnt_reconfig, .latch_count, .latch_status);
`default_nettype wire

// *** verification/test_interval_timer_control_word_decode.sv ***
// self-checking bench for the timer command byte decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_interval_timer_control_word_decode;
    import timer_cmd_pkg::*;
    logic             clock = 1'b0, rst = 1'b1, io_wr = 1'b0;
    logic [7:0]       io_addr = 8'h00, io_data = 8'h00, d;
    logic [2:0][1:0]  cnt_access;
    logic [2:0][2:0]  cnt_mode;
    logic [2:0][15:0] cnt_load_value;
    logic [2:0]       cnt_bcd, cnt_msb_next, cnt_load, cnt_bad_count, cnt_reconfig;
    logic [2:0]       latch_count, latch_status;
    logic [1:0]       acc [3];
    logic             bcd_e [3];
    logic [15:0]      val [3];
    int               n_fail = 0, checked = 0, cycles = 0;
    timer_cmd_decode dut (.clock, .rst, .io_wr, .io_addr, .io_data, .cnt_access, .cnt_mode,
        .cnt_bcd, .cnt_msb_next, .cnt_load_value, .cnt_load, .cnt_bad_count, .cnt_reconfig,
        .latch_count, .latch_status);
    always #25 clock = ~clock;
    task automatic finish_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    function automatic logic bad(input logic [15:0] v);
        return v[15:12] > 9 || v[11:8] > 9 || v[7:4] > 9 || v[3:0] > 9;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] b);
        @(posedge clock);
        io_wr   <= 1'b1;
        io_addr <= a;
        io_data <= b;
        @(posedge clock);
        io_wr <= 1'b0;
        #1;
    endtask
    task automatic cfg(input int n, input logic [1:0] a, input logic [2:0] m, input logic b);
        wr(CMD_ADDR, {2'(n), a, m, b});
        acc[n]   = a;
        bcd_e[n] = b;
        `CHK(cnt_reconfig, 3'(1 << n))
        `CHK(cnt_msb_next[n], 1'b0)
        `CHK(cnt_access[n], a)
        `CHK(cnt_mode[n], m[1] ? {2'h1, m[0]} : m)
        `CHK(cnt_bcd[n], b)
    endtask
    task automatic load(input int n, input logic [15:0] v);
        logic [15:0] e;
        logic        r;
        e = acc[n] == ACC_MSB ? {v[15:8], 8'h00} : acc[n] == ACC_LSB ? {8'h00, v[7:0]} : v;
        r = bcd_e[n] && bad(e);
        wr(COUNT_BASE + 8'(n), acc[n] == ACC_MSB ? v[15:8] : v[7:0]);
        if (acc[n] == ACC_BOTH) begin
            `CHK(cnt_msb_next[n], 1'b1)
            wr(COUNT_BASE + 8'(n), v[15:8]);
        end
        if (!r) val[n] = e;
        `CHK(cnt_load[n], !r)
        `CHK(cnt_bad_count[n], r)
        `CHK(cnt_load_value[n], val[n])
    endtask
    initial begin
        void'($urandom(89));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            acc[i]   = ACC_LSB;
            bcd_e[i] = 1'b0;
            val[i]   = 16'h0000;
            `CHK({cnt_access[i], cnt_mode[i], cnt_load_value[i]}, {ACC_LSB, 19'h0})
        end
        $display("test reset done");
        for (int i = 0; i < 48; i++) begin
            cfg(i % 3, 2'($urandom_range(3, 1)), i < 8 ? 3'(i) : 3'($urandom), 1'($urandom));
            load(i % 3, 16'($urandom));
            load(i % 3, 16'($urandom & 32'h9999));
        end
        cfg(2, ACC_BOTH, 3'h7, 1'b1);
        load(2, 16'h9999);
        load(2, 16'h9a00);
        load(2, 16'h0000);
        $display("test config and load done");
        cfg(1, ACC_BOTH, 3'h2, 1'b0);
        wr(COUNT_BASE + 8'h01, 8'h55);
        `CHK(cnt_msb_next[1], 1'b1)
        cfg(1, ACC_BOTH, 3'h2, 1'b0);
        load(1, 16'hbeef);
        $display("test restart done");
        for (int i = 0; i < 3; i++) begin
            wr(CMD_ADDR, {2'(i), 2'h0, 4'($urandom)});
            `CHK({latch_count, cnt_reconfig}, {3'(1 << i), 3'h0})
            `CHK(cnt_access[i], acc[i])
        end
        repeat (16) begin
            d = {2'h3, 6'($urandom)};
            wr(CMD_ADDR, d);
            `CHK(latch_count, ~{3{d[5]}} & d[3:1])
            `CHK({latch_status, cnt_reconfig}, {~{3{d[4]}} & d[3:1], 3'h0})
        end
        $display("test latch done");
        for (int i = 0; i < 2; i++) begin
            wr(i ? 8'h44 : 8'h3f, 8'($urandom));
            `CHK({cnt_reconfig, latch_count, cnt_load}, 9'h000)
        end
        $display("test other address done");
        finish_test();
    end
endmodule // test_interval_timer_control_word_decode
`default_nettype wire
